/* verilog/stom_pkg.sv */
// package: constants and types of the safe torque off input monitor
//
// Functional notes
// - both channels low in window enters safe
// - unfollowed channel change past window flags discrepancy
// - discrepancy window defaults to 100 ms
// - state machine evaluated once per 10 ms
// - short test pulses do not request safe state
// - no cross-circuit detection performed here
// - only the two channel inputs request it; here loss of driver supply feedback in run also forces the safe state
// - safe state removes power driver supply; supply enable here follows both channels, not the safe state
// - driver supply feedback decides safe or unsafe
// - safe state reported on outputs and fieldbus status; here only safe_torque_off_q reports it, no fieldbus status
// - no standstill monitoring while safe state active
// - request during switching honoured, raises acknowledgeable error
// - request disables control and stops switching signals
// - one acknowledge clears all acknowledgeable errors
package stom_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 40000000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int WINDOW_MS = 100;
  localparam logic [7:0] WINDOW_TICKS_RST = 8'(WINDOW_MS / TICK_MS);
  // a low pulse shorter than this many milliseconds is a test pulse
  localparam int PULSE_MS = 1;
  localparam int PULSE_CYCLES = CLK_HZ / 1000 * PULSE_MS;
  localparam int FILT_W = 16;
  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    STOM_RUN = 4'h1,
    STOM_DISC = 4'h2,
    STOM_SAFE = 4'h4,
    STOM_ERR = 4'h8
  } stom_state_t;
endpackage

/* verilog/stom_tick.sv */
// tick generator for the monitoring state machine
`timescale 1ns/10ps
module stom_tick #(
  parameter int TICK_CYCLES = stom_pkg::TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  output logic tick_q
);
  import stom_pkg::*;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic tick_d;
  always_comb begin
    tick_d = 1'b0;
    cnt_d = cnt_q + 32'h1;
    if (cnt_q >= 32'(TICK_CYCLES - 1)) begin
      cnt_d = 32'h0;
      tick_d = 1'b1;
    end
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_q <= 32'h0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end
endmodule

/* verilog/stom_filter.sv */
// synchroniser and test pulse filter for one safety channel
`timescale 1ns/10ps
module stom_filter #(
  parameter int PULSE_CYCLES = stom_pkg::PULSE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic raw_in,
  output logic run_q
);
  import stom_pkg::*;
  logic meta_q;
  logic sync_q;
  logic [FILT_W-1:0] low_q;
  logic [FILT_W-1:0] low_d;
  logic run_d;
  // low only after it persists; high passes at once so a run is seen fast
  always_comb begin
    low_d = low_q;
    run_d = run_q;
    if (sync_q) begin
      low_d = '0;
      run_d = 1'b1;
    end else if (low_q >= FILT_W'(PULSE_CYCLES - 1)) begin
      run_d = 1'b0;
    end else begin
      low_d = low_q + FILT_W'(1);
    end
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      low_q <= '0;
      run_q <= 1'b0;
    end else begin
      meta_q <= raw_in;
      sync_q <= meta_q;
      low_q <= low_d;
      run_q <= run_d;
    end
  end
endmodule

/* verilog/stom_monitor.sv */
// safe torque off input monitor top
`timescale 1ns/10ps
module stom_monitor #(
  parameter int TICK_CYCLES = stom_pkg::TICK_CYCLES,
  parameter int PULSE_CYCLES = stom_pkg::PULSE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic safety_channel_a_in,
  input wire logic safety_channel_b_in,
  input wire logic driver_supply_ok_in,
  input wire logic pwm_active_in,
  input wire logic drive_enable_req,
  input wire logic error_ack,
  output logic driver_supply_en_q,
  output logic drive_ctrl_en_q,
  output logic pwm_allow_q,
  output logic standstill_mon_en_q,
  output logic safe_torque_off_q,
  output logic disc_error_q,
  output logic pwm_req_error_q,
  output stom_pkg::stom_state_t state_q
);
  import stom_pkg::*;
  // ------------------------------------------------------------
  // channel conditioning
  // ------------------------------------------------------------
  logic run_a;
  logic run_b;
  logic tick;
  logic sup_meta_q;
  logic sup_q;
  stom_filter #(.PULSE_CYCLES(PULSE_CYCLES)) u_filt_a (
    .clk_sys(clk_sys),
    .reset(reset),
    .raw_in(safety_channel_a_in),
    .run_q(run_a)
  );
  stom_filter #(.PULSE_CYCLES(PULSE_CYCLES)) u_filt_b (
    .clk_sys(clk_sys),
    .reset(reset),
    .raw_in(safety_channel_b_in),
    .run_q(run_b)
  );
  stom_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clk_sys(clk_sys),
    .reset(reset),
    .tick_q(tick)
  );
  // driver supply feedback is a pin too, so synchronise it
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sup_meta_q <= 1'b0;
      sup_q <= 1'b0;
    end else begin
      sup_meta_q <= driver_supply_ok_in;
      sup_q <= sup_meta_q;
    end
  end
  // ------------------------------------------------------------
  // state machine
  // ------------------------------------------------------------
  // no cross-circuit check: channels are only compared, never pulsed
  stom_state_t state_d;
  logic [7:0] win_q;
  logic [7:0] win_d;
  logic disc_d;
  logic pwmerr_d;
  logic both_low;
  logic both_high;
  logic safe_now;
  assign both_low = !run_a && !run_b;
  assign both_high = run_a && run_b;
  always_comb begin
    state_d = state_q;
    win_d = win_q;
    disc_d = disc_error_q;
    pwmerr_d = pwm_req_error_q;
    if (error_ack) begin
      disc_d = 1'b0;
      pwmerr_d = 1'b0;
    end
    if (tick) begin
      case (state_q)
        STOM_RUN: begin
          if (both_low || !sup_q) begin
            state_d = STOM_SAFE;
            if (pwm_active_in) begin
              pwmerr_d = 1'b1;
            end
          end else if (!both_high) begin
            state_d = STOM_DISC;
            win_d = WINDOW_TICKS_RST;
          end
        end
        STOM_DISC: begin
          if (both_low) begin
            state_d = STOM_SAFE;
            if (pwm_active_in) begin
              pwmerr_d = 1'b1;
            end
          end else if (both_high) begin
            state_d = sup_q ? STOM_RUN : STOM_SAFE;
          end else if (win_q <= 8'h1) begin
            state_d = STOM_ERR;
            disc_d = 1'b1;
          end else begin
            win_d = win_q - 8'h1;
          end
        end
        STOM_SAFE: begin
          if (both_high && sup_q) begin
            state_d = STOM_RUN;
          end else if (!both_low) begin
            state_d = STOM_DISC;
            win_d = WINDOW_TICKS_RST;
          end
        end
        STOM_ERR: begin
          if (both_low) begin
            state_d = STOM_SAFE;
          end else if (both_high && sup_q && !disc_error_q) begin
            state_d = STOM_RUN;
          end
        end
        default: begin
          state_d = STOM_SAFE;
        end
      endcase
    end
  end
  // the two channels request it directly; supply feedback also feeds in via state_d
  assign safe_now = (state_d != STOM_RUN) || both_low;
  // ------------------------------------------------------------
  // output decode
  // ------------------------------------------------------------
  // one gate for the control, pwm and standstill enables so none of them can bypass the safe decision
  function automatic logic enable_gate(input logic safe, input logic req);
    enable_gate = !safe && req;
  endfunction
  logic supply_en_d;
  logic ctrl_en_d;
  logic pwm_allow_d;
  logic still_en_d;
  logic sto_d;
  always_comb begin
    // supply cut follows channels directly, not the slow state machine
    supply_en_d = run_a && run_b;
    ctrl_en_d = enable_gate(safe_now, drive_enable_req);
    pwm_allow_d = enable_gate(safe_now, drive_enable_req);
    still_en_d = enable_gate(safe_now, drive_enable_req);
    sto_d = (state_d == STOM_SAFE);
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_q <= STOM_SAFE;
      win_q <= 8'h0;
      disc_error_q <= 1'b0;
      pwm_req_error_q <= 1'b0;
      driver_supply_en_q <= 1'b0;
      drive_ctrl_en_q <= 1'b0;
      pwm_allow_q <= 1'b0;
      standstill_mon_en_q <= 1'b0;
      safe_torque_off_q <= 1'b1;
    end else begin
      state_q <= state_d;
      win_q <= win_d;
      disc_error_q <= disc_d;
      pwm_req_error_q <= pwmerr_d;
      driver_supply_en_q <= supply_en_d;
      drive_ctrl_en_q <= ctrl_en_d;
      pwm_allow_q <= pwm_allow_d;
      standstill_mon_en_q <= still_en_d;
      safe_torque_off_q <= sto_d;
    end
  end
  // ------------------------------------------------------------
  // checks: outputs
  // ------------------------------------------------------------
  AST_SUPPLY_CUT: assert property (@(posedge clk_sys) disable iff (reset)
    (!run_a || !run_b) |=> !driver_supply_en_q)
    else $error("driver supply not cut");
  AST_SUPPLY_ON: assert property (@(posedge clk_sys) disable iff (reset)
    (run_a && run_b) |=> driver_supply_en_q)
    else $error("driver supply not restored");
  AST_PWM_OFF: assert property (@(posedge clk_sys) disable iff (reset)
    (state_q == STOM_SAFE) |-> !pwm_allow_q)
    else $error("pwm allowed in safe");
  AST_CTRL_OFF: assert property (@(posedge clk_sys) disable iff (reset)
    both_low |=> !drive_ctrl_en_q)
    else $error("drive control on with both low");
  AST_CTRL_NEEDS_REQ: assert property (@(posedge clk_sys) disable iff (reset)
    !drive_enable_req |=> !drive_ctrl_en_q)
    else $error("drive control on without request");
  AST_CTRL_NEEDS_RUN: assert property (@(posedge clk_sys) disable iff (reset)
    (state_q != STOM_RUN) |-> !drive_ctrl_en_q)
    else $error("drive control on outside run");
  AST_PWM_MATCH: assert property (@(posedge clk_sys) disable iff (reset)
    pwm_allow_q == drive_ctrl_en_q)
    else $error("pwm allow differs from drive control");
  AST_STO_NO_CTRL: assert property (@(posedge clk_sys) disable iff (reset)
    safe_torque_off_q |-> !drive_ctrl_en_q && !pwm_allow_q)
    else $error("drive control on while safe reported");
  AST_NO_STANDSTILL: assert property (@(posedge clk_sys) disable iff (reset)
    safe_torque_off_q |-> !standstill_mon_en_q)
    else $error("standstill monitored in safe");
  AST_STANDSTILL_MATCH: assert property (@(posedge clk_sys) disable iff (reset)
    standstill_mon_en_q == drive_ctrl_en_q)
    else $error("standstill enable differs from drive control");
  AST_REPORT: assert property (@(posedge clk_sys) disable iff (reset)
    (state_q == STOM_SAFE) |-> safe_torque_off_q)
    else $error("safe state not reported");
  AST_REPORT_MATCH: assert property (@(posedge clk_sys) disable iff (reset)
    safe_torque_off_q |-> (state_q == STOM_SAFE))
    else $error("safe reported outside safe state");
  // ------------------------------------------------------------
  // checks: state machine
  // ------------------------------------------------------------
  AST_ONEHOT: assert property (@(posedge clk_sys) disable iff (reset)
    $onehot(state_q))
    else $error("state not one-hot");
  AST_TICK_ONLY: assert property (@(posedge clk_sys) disable iff (reset)
    !tick |=> $stable(state_q))
    else $error("state moved off tick");
  AST_ENTER_SAFE: assert property (@(posedge clk_sys) disable iff (reset)
    (tick && both_low) |=> (state_q == STOM_SAFE))
    else $error("safe not entered");
  AST_DISC_ENTRY: assert property (@(posedge clk_sys) disable iff (reset)
    (tick && state_q == STOM_RUN && !both_low && !both_high && sup_q) |=> (state_q == STOM_DISC))
    else $error("discrepancy state not entered");
  AST_WIN_LOAD: assert property (@(posedge clk_sys) disable iff (reset)
    (tick && state_q == STOM_RUN && !both_low && !both_high && sup_q) |=> (win_q == WINDOW_TICKS_RST))
    else $error("window not loaded");
  AST_WIN_SAFE_LOAD: assert property (@(posedge clk_sys) disable iff (reset)
    (tick && state_q == STOM_SAFE && !both_low && !(both_high && sup_q))
    |=> (win_q == WINDOW_TICKS_RST) && (state_q == STOM_DISC))
    else $error("window not loaded from safe");
  AST_DISC_COUNT: assert property (@(posedge clk_sys) disable iff (reset)
    (tick && state_q == STOM_DISC && !both_low && !both_high && win_q > 8'h1)
    |=> (win_q == $past(win_q) - 8'h1))
    else $error("window not counted down");
  AST_DISC_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
    (state_q == STOM_DISC && !tick) |=> $stable(win_q))
    else $error("window moved off tick");
  AST_DISC_SET: assert property (@(posedge clk_sys) disable iff (reset)
    (tick && state_q == STOM_DISC && !both_low && !both_high && win_q <= 8'h1)
    |=> disc_error_q && state_q == STOM_ERR)
    else $error("discrepancy not flagged");
  AST_DISC_RESOLVE: assert property (@(posedge clk_sys) disable iff (reset)
    (tick && state_q == STOM_DISC && both_high && sup_q) |=> (state_q == STOM_RUN))
    else $error("agreed channels did not resume run");
  AST_SUPPLY_LOSS: assert property (@(posedge clk_sys) disable iff (reset)
    (tick && state_q == STOM_RUN && !sup_q) |=> (state_q == STOM_SAFE))
    else $error("supply loss did not force safe");
  AST_RUN_NEEDS_SUPPLY: assert property (@(posedge clk_sys) disable iff (reset)
    (tick && !sup_q) |=> (state_q != STOM_RUN))
    else $error("run entered without supply");
  AST_SAFE_RELEASE: assert property (@(posedge clk_sys) disable iff (reset)
    (tick && state_q == STOM_SAFE && both_high && sup_q) |=> (state_q == STOM_RUN))
    else $error("safe not released");
  AST_ERR_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
    (tick && state_q == STOM_ERR && disc_error_q && !both_low) |=> (state_q == STOM_ERR))
    else $error("error state left unacknowledged");
  // ------------------------------------------------------------
  // checks: errors
  // ------------------------------------------------------------
  AST_ACK_CLEAR: assert property (@(posedge clk_sys) disable iff (reset)
    (error_ack && !tick) |=> !disc_error_q && !pwm_req_error_q)
    else $error("ack did not clear");
  AST_LATCH: assert property (@(posedge clk_sys) disable iff (reset)
    (disc_error_q && !error_ack) |=> disc_error_q)
    else $error("error not latched");
  AST_DISC_ONLY_EXPIRY: assert property (@(posedge clk_sys) disable iff (reset)
    (!disc_error_q && !(tick && state_q == STOM_DISC)) |=> !disc_error_q)
    else $error("discrepancy error without expiry");
  AST_PWM_ERR: assert property (@(posedge clk_sys) disable iff (reset)
    (tick && state_q == STOM_RUN && both_low && pwm_active_in) |=> pwm_req_error_q)
    else $error("pwm request error missing");
  AST_PWM_ERR_DISC: assert property (@(posedge clk_sys) disable iff (reset)
    (tick && state_q == STOM_DISC && both_low && pwm_active_in) |=> pwm_req_error_q)
    else $error("pwm request error missing after skew");
  AST_PWM_ERR_LATCH: assert property (@(posedge clk_sys) disable iff (reset)
    (pwm_req_error_q && !error_ack) |=> pwm_req_error_q)
    else $error("pwm request error not latched");
  AST_PWM_ERR_ONLY_ACTIVE: assert property (@(posedge clk_sys) disable iff (reset)
    (!pwm_req_error_q && !pwm_active_in) |=> !pwm_req_error_q)
    else $error("pwm request error without switching");
  COV_SAFE: cover property (@(posedge clk_sys) disable iff (reset)
    state_q == STOM_RUN ##1 state_q == STOM_SAFE);
  COV_DISC_OK: cover property (@(posedge clk_sys) disable iff (reset)
    state_q == STOM_DISC ##1 state_q == STOM_SAFE);
  COV_DISC_ERR: cover property (@(posedge clk_sys) disable iff (reset)
    $rose(disc_error_q));
  COV_PWM_ERR: cover property (@(posedge clk_sys) disable iff (reset)
    $rose(pwm_req_error_q));
endmodule

/* verif/stom_relay_model.sv */
// two-output safety relay model driving the monitor channels
`timescale 1ns/10ps
module stom_relay_model #(
  parameter int PULSE_LEN = 2
) (
  input wire logic clk_sys,
  input wire logic stop_a,
  input wire logic stop_b,
  input wire logic test_pulse,
  output logic out_a,
  output logic out_b
);
  int pulse_cnt = 0;
  // a test pulse drops both outputs for PULSE_LEN cycles
  always @(posedge clk_sys) begin
    if (test_pulse) begin
      pulse_cnt <= PULSE_LEN;
    end else if (pulse_cnt > 0) begin
      pulse_cnt <= pulse_cnt - 1;
    end
  end
  // a stop removes the control level, contacts always driven
  assign out_a = !stop_a && (pulse_cnt == 0);
  assign out_b = !stop_b && (pulse_cnt == 0);
endmodule

/* verif/stom_monitor_tb_top.sv */
// testbench of the safe torque off input monitor
`timescale 1ns/10ps
module stom_monitor_tb_top;
  import stom_pkg::*;
  localparam int TICK = 50;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic stop_a = 1'b0;
  logic stop_b = 1'b0;
  logic test_pulse = 1'b0;
  logic supply_ok = 1'b0;
  logic supply_fail = 1'b0;
  logic pwm_active = 1'b0;
  logic enable_req = 1'b1;
  logic ack = 1'b0;
  logic chan_a, chan_b, supply_en, ctrl_en, pwm_allow, still_en, safe_torque_off, disc_err, pwm_err;
  stom_state_t state;
  int n_errors = 0;
  int n_checks = 0;

  always #12.5 clk_sys = ~clk_sys;
  // supply feedback follows the enable a cycle later, unless a fault is injected
  always @(posedge clk_sys) supply_ok <= supply_en && !supply_fail;

  stom_relay_model #(.PULSE_LEN(2)) i_stom_relay_model (.clk_sys(clk_sys), .stop_a(stop_a), .stop_b(stop_b),
    .test_pulse(test_pulse), .out_a(chan_a), .out_b(chan_b));
  stom_monitor #(.TICK_CYCLES(TICK), .PULSE_CYCLES(4)) i_stom_monitor (.clk_sys(clk_sys), .reset(reset),
    .safety_channel_a_in(chan_a), .safety_channel_b_in(chan_b), .driver_supply_ok_in(supply_ok),
    .pwm_active_in(pwm_active), .drive_enable_req(enable_req), .error_ack(ack),
    .driver_supply_en_q(supply_en), .drive_ctrl_en_q(ctrl_en), .pwm_allow_q(pwm_allow),
    .standstill_mon_en_q(still_en), .safe_torque_off_q(safe_torque_off), .disc_error_q(disc_err),
    .pwm_req_error_q(pwm_err), .state_q(state));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic wait_state(input stom_state_t exp, input int max);
    for (int i = 0; i < max && state !== exp; i++) step(1);
    chk("state", exp, state);
    if (state !== exp) conclude();
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic sc_run();
    stop_a = 1'b0;
    stop_b = 1'b0;
    wait_state(STOM_RUN, 4 * TICK);
    step(2);
    chk("run enables", 4'hF, {supply_en, ctrl_en, pwm_allow, still_en});
    chk("sto run", 4'h0, safe_torque_off);
  endtask
  task automatic sc_pulse();
    test_pulse = 1'b1;
    step(1);
    test_pulse = 1'b0;
    step(3 * TICK);
    chk("pulse state", STOM_RUN, state);
    chk("pulse supply", 4'h1, supply_en);
  endtask
  task automatic sc_drop(input logic pwm);
    pwm_active = pwm;
    stop_a = 1'b1;
    stop_b = 1'b1;
    for (int i = 0; i < 20 && supply_en !== 1'b0; i++) step(1);
    chk("supply cut", 4'h0, supply_en);
    step(2);
    chk("ctrl off", 4'h0, {ctrl_en, pwm_allow, still_en});
    wait_state(STOM_SAFE, TICK + 4);
    step(2);
    chk("sto safe", 4'h1, safe_torque_off);
    chk("pwm error", {3'h0, pwm}, pwm_err);
    chk("no disc", 4'h0, disc_err);
    pwm_active = 1'b0;
  endtask
  task automatic sc_ack();
    ack = 1'b1;
    step(1);
    ack = 1'b0;
    step(2);
    chk("errors cleared", 4'h0, {disc_err, pwm_err});
  endtask
  task automatic sc_skew();
    stop_a = 1'b1;
    step(4 * TICK);
    stop_b = 1'b1;
    wait_state(STOM_SAFE, 2 * TICK);
    chk("skew no disc", 4'h0, disc_err);
  endtask
  task automatic sc_disc();
    stop_a = 1'b1;
    step(8 * TICK);
    chk("disc early", 4'h0, disc_err);
    wait_state(STOM_ERR, 5 * TICK);
    chk("disc set", 4'h1, disc_err);
    stop_a = 1'b0;
    step(3 * TICK);
    chk("disc latched", 4'h1, disc_err);
    sc_ack();
    wait_state(STOM_RUN, 3 * TICK);
  endtask
  task automatic sc_enable();
    enable_req = 1'b0;
    step(2 * TICK);
    chk("enable low state", STOM_RUN, state);
    chk("enable low sto", 4'h0, {safe_torque_off, ctrl_en});
    enable_req = 1'b1;
    step(2);
  endtask
  task automatic sc_supply();
    supply_fail = 1'b1;
    wait_state(STOM_SAFE, 2 * TICK);
    supply_fail = 1'b0;
    wait_state(STOM_RUN, 3 * TICK);
  endtask

  initial begin
    step(15);
    chk("reset state", STOM_SAFE, state);
    chk("reset outputs", 4'h8, {safe_torque_off, ctrl_en, disc_err, pwm_err});
    step(1);
    reset = 1'b0;
    sc_run();
    sc_pulse();
    sc_drop(1'b0);
    sc_run();
    sc_drop(1'b1);
    sc_ack();
    sc_run();
    sc_skew();
    sc_run();
    sc_disc();
    sc_enable();
    sc_supply();
    conclude();
  end
endmodule
